// >>> opsc_port.sv
// Four-bit output port with timer clock and oscillator clock special outputs.
`timescale 1ns/1ps
// Contract
// R01: Four independent output bits, each on its own terminal.
// R02: Each bit chosen at build time as push-pull or high-side open drain.
// R03: Reset clears data and float bits so all terminals drive low; open-drain bits are released instead.
// R04: After reset all bits are plain data outputs, special clocks off.
// R05: Float control 1 floats the terminal regardless of data or clocks.
// R06: Float control 0 drives the terminal from its data bit.
// R07: Bit 2 may carry timer clock, bit 3 oscillator clock; bits 0,1 plain.
// R08: Software sets data 1, float 0 before using a special clock.
// R09: Data 0 on bit 2 or 3 holds the terminal low even with clock selected.
// R10: Float 1 on bit 2 or 3 floats it even with clock selected.
// R11: Bit 2 carries timer clock gated by the timer output gate.
// R12: Bit 2 clock is the programmable timer output, not local.
// R13: Software must run the programmable timer for bit 2 to toggle.
// R14: Bit 3 carries oscillator clock gated by the clock output enable.
// R15: Select 11 high-speed, 10 low-speed, 01 low-speed/8, 00 low-speed/64.
// R16: Software starts and settles the high-speed oscillator before use.
// R17: Gating is not glitch-free; short pulses may occur on switching.
// R18: Clock enable 0 stops the oscillator clock on bit 3.
// R19: Timer gate 0 on a configured bit 2 drives it high.
// R20: Control bits are written synchronously and read back as written.
module opsc_port #(
    parameter logic [3:0] OPEN_DRAIN = opsc_pkg::OPEN_DRAIN_DEF
) (
    input  wire logic                        clk_in,
    input  wire logic                        rst_in,
    input  wire logic [opsc_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [opsc_pkg::DATA_W-1:0] wdata_in,
    input  wire logic                        wr_in,
    input  wire logic                        rd_in,
    output logic      [opsc_pkg::DATA_W-1:0] rdata_out,
    input  wire logic                        timer_clock_in,
    input  wire logic                        low_speed_osc_clk_in,
    input  wire logic                        high_speed_osc_clk_in,
    output logic      [3:0]                  pin_out,
    output logic      [3:0]                  pin_oe_out
);

    // ************************************************************
    // State and next-state copies
    // ************************************************************
    opsc_pkg::opsc_state_t st;
    opsc_pkg::opsc_state_t next_st;
    logic [3:0]            next_lvl;
    logic                  osc_clock_out;
    logic                  ls_rise;

    // The low-speed input is already synchronous; its rising edge is the divider enable.
    assign ls_rise = low_speed_osc_clk_in & ~st.ls_prev;

    // Oscillator clock selection; a plain mux, so a select change may cut a pulse. R17
    always_comb begin
        case (st.freq)
            opsc_pkg::FREQ_HS:      osc_clock_out = high_speed_osc_clk_in; // R15
            opsc_pkg::FREQ_LS:      osc_clock_out = low_speed_osc_clk_in; // R15
            opsc_pkg::FREQ_LS_DIV8: osc_clock_out = st.div[opsc_pkg::DIV8_TAP]; // R15
            default:                osc_clock_out = st.div[opsc_pkg::DIV64_TAP]; // R15
        endcase
    end

    // ************************************************************
    // Per-bit terminal level
    // ************************************************************
    // Each level is the data bit, ANDed with the gated clock on bits 2 and 3.
    // A clock that is not gated on passes a 1, so the data bit shows as DC.
    genvar gi;
    generate
        for (gi = 0; gi < opsc_pkg::NUM_BITS; gi = gi + 1) begin : g_bit
            if (gi == opsc_pkg::TIMER_BIT) begin : g_tim
                // R11 R12 R19 R09
                assign next_lvl[gi] = st.data[gi] & (st.tim_gate ? timer_clock_in : 1'b1);
            end else if (gi == opsc_pkg::OSC_BIT) begin : g_osc
                // R14 R18 R09
                assign next_lvl[gi] = st.data[gi] & (st.osc_en ? osc_clock_out : 1'b1);
            end else begin : g_plain
                assign next_lvl[gi] = st.data[gi]; // R07 R06
            end
            // Open drain only pulls high, so a low level releases the pin.
            assign pin_out[gi]    = OPEN_DRAIN[gi] ? 1'b1 : st.lvl[gi]; // R02
            assign pin_oe_out[gi] = st.drv[gi] & (~OPEN_DRAIN[gi] | st.lvl[gi]); // R02 R05
        end
    endgenerate

    assign rdata_out = st.rdata;

    // ************************************************************
    // Next state: register writes, reads, divider and pins
    // ************************************************************
    // Writes land in the cycle after the strobe; reads answer one cycle later.
    always_comb begin
        next_st         = st;
        next_st.ls_prev = low_speed_osc_clk_in;
        if (ls_rise) begin
            next_st.div = st.div + 6'h01;
        end
        if (wr_in) begin
            case (addr_in)
                opsc_pkg::REG_DATA:  next_st.data = wdata_in; // R20
                opsc_pkg::REG_FLOAT: next_st.flt  = wdata_in; // R20
                opsc_pkg::REG_CLKCTL: begin
                    next_st.freq     = wdata_in[opsc_pkg::FLD_FREQ_HI:opsc_pkg::FLD_FREQ_LO];
                    next_st.osc_en   = wdata_in[opsc_pkg::FLD_OSC_EN];
                    next_st.tim_gate = wdata_in[opsc_pkg::FLD_TIM_GATE];
                end
                default: ;
            endcase
        end
        next_st.rdata = 4'h0;
        if (rd_in) begin
            case (addr_in)
                opsc_pkg::REG_DATA:   next_st.rdata = st.data; // R20
                opsc_pkg::REG_FLOAT:  next_st.rdata = st.flt; // R20
                opsc_pkg::REG_CLKCTL: next_st.rdata = {st.tim_gate, st.osc_en, st.freq};
                default:              next_st.rdata = 4'h0;
            endcase
        end
        next_st.lvl = next_lvl;
        next_st.drv = ~st.flt; // R05 R06 R10
    end

    // Register the whole state; reset puts every push-pull pin driving low and releases open-drain pins.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st.data     <= opsc_pkg::RST_DATA; // R03
            st.flt      <= opsc_pkg::RST_FLOAT; // R03
            st.freq     <= opsc_pkg::RST_FREQ;
            st.osc_en   <= 1'b0; // R04
            st.tim_gate <= 1'b0; // R04
            st.div      <= 6'h00;
            st.ls_prev  <= 1'b0;
            st.rdata    <= 4'h0;
            st.lvl      <= 4'h0; // R03
            st.drv      <= 4'hf; // R03
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_wr_data;
        wr_in && (addr_in == opsc_pkg::REG_DATA);
    endsequence

    sequence s_rd_data;
        rd_in && (addr_in == opsc_pkg::REG_DATA) && !wr_in;
    endsequence

    property p_reset_low;
        // The default disable would mute this check, so it is switched off here on purpose.
        @(posedge clk_in) disable iff (1'b0)
            rst_in |=> (st.lvl == 4'h0) && (st.drv == 4'hf) && !st.tim_gate;
    endproperty

    AST_RESET_LOW: assert property (p_reset_low) // R03
        else $error("Reset did not leave all terminals driving low.");

    AST_FLOAT_WINS: assert property (st.flt[3] |=> !pin_oe_out[3]) // R05
        else $error("Floated bit 3 is still driven.");

    AST_TIMER_FLOAT: assert property (st.flt[2] && st.tim_gate |=> !pin_oe_out[2]) // R10
        else $error("Floated bit 2 is driven while timer clock selected.");

    AST_PLAIN_BITS: assert property (1'b1 |=> st.lvl[1:0] == $past(st.data[1:0])) // R07
        else $error("Bits 0 and 1 do not follow their data.");

    AST_DATA0_LOW: assert property (!st.data[2] && !st.data[3] |=> st.lvl[3:2] == 2'h0) // R09
        else $error("Special bit with data 0 is not low.");

    AST_TIMER_PASS: assert property (st.data[2] && st.tim_gate
        |=> st.lvl[2] == $past(timer_clock_in)) // R11
        else $error("Timer clock not passed to bit 2.");

    AST_TIMER_IDLE: assert property (st.data[2] && !st.tim_gate ##1 st.data[2]
        |-> st.lvl[2]) // R19
        else $error("Bit 2 not high with timer gate off.");

    AST_OSC_HS: assert property (st.data[3] && st.osc_en && st.freq == opsc_pkg::FREQ_HS
        |=> st.lvl[3] == $past(high_speed_osc_clk_in)) // R15
        else $error("High-speed clock not routed to bit 3.");

    AST_OSC_DIV8: assert property (st.data[3] && st.osc_en && st.freq == opsc_pkg::FREQ_LS_DIV8
        |=> st.lvl[3] == $past(st.div[opsc_pkg::DIV8_TAP])) // R15
        else $error("Divide-by-8 clock not routed to bit 3.");

    AST_DIV_COUNT: assert property (ls_rise |=> st.div == $past(st.div) + 6'h01) // R15
        else $error("Low-speed divider missed an edge.");

    AST_OSC_OFF: assert property (!st.osc_en |=> st.lvl[3] == $past(st.data[3])) // R18
        else $error("Oscillator clock leaks onto bit 3 while disabled.");

    AST_READBACK: assert property (s_wr_data ##1 s_rd_data
        |=> rdata_out == $past(wdata_in, 2)) // R20
        else $error("Data register did not read back the written value.");

endmodule

// >>> opsc_pkg.sv
// Package of constants and state types for the output port with special clock outputs.
package opsc_pkg;

    // ************************************************************
    // Register map and field layout
    // ************************************************************
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 4;
    localparam int          NUM_BITS      = 4;
    localparam logic [3:0]  REG_DATA      = 4'h0;
    localparam logic [3:0]  REG_FLOAT     = 4'h1;
    localparam logic [3:0]  REG_CLKCTL    = 4'h2;
    localparam int          FLD_FREQ_LO   = 0;
    localparam int          FLD_FREQ_HI   = 1;
    localparam int          FLD_OSC_EN    = 2;
    localparam int          FLD_TIM_GATE  = 3;
    localparam int          TIMER_BIT     = 2;
    localparam int          OSC_BIT       = 3;

    // ************************************************************
    // Reset values, encodings and build options
    // ************************************************************
    localparam logic [3:0]  RST_DATA      = 4'h0;
    localparam logic [3:0]  RST_FLOAT     = 4'h0;
    localparam logic [1:0]  RST_FREQ      = 2'h0;
    localparam logic [1:0]  FREQ_HS       = 2'h3;
    localparam logic [1:0]  FREQ_LS       = 2'h2;
    localparam logic [1:0]  FREQ_LS_DIV8  = 2'h1;
    localparam logic [1:0]  FREQ_LS_DIV64 = 2'h0;
    localparam int          DIV_W         = 6;
    localparam int          DIV8_TAP      = 2;
    localparam int          DIV64_TAP     = 5;
    localparam logic [3:0]  OPEN_DRAIN_DEF = 4'h0;

    // All state of the port in one record.
    typedef struct packed {
        logic [3:0]       data;
        logic [3:0]       flt;
        logic [1:0]       freq;
        logic             osc_en;
        logic             tim_gate;
        logic [DIV_W-1:0] div;
        logic             ls_prev;
        logic [3:0]       rdata;
        logic [3:0]       lvl;
        logic [3:0]       drv;
    } opsc_state_t;

endpackage

// >>> opsc_far.sv
// Far-side model: clock sources feeding the port and devices clocked by bits 2 and 3.
`timescale 1ns/1ps
module opsc_far (
    input  wire logic       clk_in,
    input  wire logic       clr_in,
    input  wire logic [3:0] pin_in,
    input  wire logic [3:0] oe_in,
    output logic            tim_out,
    output logic            ls_out,
    output logic            hs_out,
    output int              rise2_out,
    output int              rise3_out
);
    logic [3:0] last = 4'h0;
    logic [3:0] prev = 4'h0;
    logic [3:0] lvl;
    int         ph = 0;
    initial tim_out = 1'b0;
    initial ls_out = 1'b0;
    initial hs_out = 1'b0;
    // A released line has no pull, so it shows the inverse of the last driven level.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lvl[i] = oe_in[i] ? pin_in[i] : ~last[i];
        end
    end
    // Sources change just after the edge; the devices count rising edges of their lines.
    always @(posedge clk_in) begin
        ph <= ph + 1;
        hs_out <= ~hs_out;
        if (ph % 2 == 1) ls_out <= ~ls_out;
        if (ph % 3 == 2) tim_out <= ~tim_out;
        for (int i = 0; i < 4; i++) if (oe_in[i]) last[i] <= pin_in[i];
        prev <= lvl;
        if (clr_in) rise2_out <= 0;
        else if (lvl[2] & ~prev[2]) rise2_out <= rise2_out + 1;
        if (clr_in) rise3_out <= 0;
        else if (lvl[3] & ~prev[3]) rise3_out <= rise3_out + 1;
    end
endmodule

// >>> opsc_port_tb.sv
// Self-checking bench for the output port with special clock outputs.
`timescale 1ns/1ps
module opsc_port_tb;
    // ************************************************************
    // Signals, clock and instances
    // ************************************************************
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       wr_in = 1'b0;
    logic       rd_in = 1'b0;
    logic       clr = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [3:0] wdata_in = 4'h0;
    logic [3:0] rdata_out, pin_out, pin_oe_out;
    logic       tim, ls, hs;
    int         rise2, rise3;
    int         n_fail = 0;
    int         n_checks = 0;
    always #5 clk_in = ~clk_in;
    opsc_port opsc_port_inst (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .timer_clock_in(tim), .low_speed_osc_clk_in(ls), .high_speed_osc_clk_in(hs),
        .pin_out(pin_out), .pin_oe_out(pin_oe_out));
    opsc_far opsc_far_inst (.clk_in(clk_in), .clr_in(clr), .pin_in(pin_out),
        .oe_in(pin_oe_out), .tim_out(tim), .ls_out(ls), .hs_out(hs),
        .rise2_out(rise2), .rise3_out(rise3));
    // ************************************************************
    // Bus cycles and comparisons
    // ************************************************************
    task automatic conclude();
        if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            n_fail++;
            $display("unexpected at %0t: edge count %0d, wanted %0d", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [3:0] exp);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, exp);
    endtask
    // A write and a read of the same register with no idle cycle between them.
    task automatic wrrd(input logic [3:0] a, input logic [3:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, d);
        @(posedge clk_in);
        #1 chk(rdata_out, 4'h0);
    endtask
    // Pins follow a control write one edge after the strobe edge.
    task automatic settle();
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    // The window spans whole periods of every source, so edge counts are exact.
    // The clear waits until a prior control write has reached the pins.
    task automatic window();
        repeat (2) @(posedge clk_in);
        clr <= 1'b1;
        @(posedge clk_in);
        clr <= 1'b0;
        repeat (768) @(posedge clk_in);
        #1;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs();
        wrrd(opsc_pkg::REG_DATA, 4'h9);
        wr(opsc_pkg::REG_FLOAT, 4'hA);
        rd(opsc_pkg::REG_FLOAT, 4'hA);
        wr(opsc_pkg::REG_CLKCTL, 4'hF);
        rd(opsc_pkg::REG_CLKCTL, 4'hF);
        wr(4'h7, 4'h5);
        rd(4'h7, 4'h0);
        wr(opsc_pkg::REG_CLKCTL, 4'h0);
    endtask
    task automatic t_plain();
        logic [3:0] d[4] = '{4'h5, 4'hA, 4'hF, 4'h3};
        logic [3:0] f[4] = '{4'h0, 4'h3, 4'hC, 4'hF};
        for (int i = 0; i < 4; i++) begin
            wr(opsc_pkg::REG_DATA, d[i]);
            wr(opsc_pkg::REG_FLOAT, f[i]);
            settle();
            chk(pin_oe_out, ~f[i]);
            chk(pin_out & pin_oe_out, d[i] & ~f[i]);
        end
        wr(opsc_pkg::REG_FLOAT, 4'h0);
    endtask
    task automatic t_timer();
        wr(opsc_pkg::REG_DATA, 4'hF);
        wr(opsc_pkg::REG_CLKCTL, 4'h8);
        window();
        chkn(rise2, 128);
        chkn(rise3, 0);
        chk(pin_out[1:0], 4'h3);
        wr(opsc_pkg::REG_CLKCTL, 4'h0);
        window();
        chkn(rise2, 0);
        chk(pin_out[2], 1'b1);
        wr(opsc_pkg::REG_CLKCTL, 4'h8);
        wr(opsc_pkg::REG_DATA, 4'hB);
        window();
        chkn(rise2, 0);
        chk(pin_out[2], 1'b0);
        wr(opsc_pkg::REG_DATA, 4'hF);
        wr(opsc_pkg::REG_FLOAT, 4'h4);
        settle();
        chk(pin_oe_out, 4'hB);
        wr(opsc_pkg::REG_FLOAT, 4'h0);
        wr(opsc_pkg::REG_CLKCTL, 4'h0);
    endtask
    task automatic t_osc();
        logic [1:0] fs[4] = '{opsc_pkg::FREQ_HS, opsc_pkg::FREQ_LS,
                              opsc_pkg::FREQ_LS_DIV8, opsc_pkg::FREQ_LS_DIV64};
        int         ex[4] = '{384, 192, 24, 3};
        for (int i = 0; i < 4; i++) begin
            wr(opsc_pkg::REG_CLKCTL, {2'h1, fs[i]});
            window();
            chkn(rise3, ex[i]);
            chkn(rise2, 0);
        end
        wr(opsc_pkg::REG_CLKCTL, 4'h0);
        window();
        chkn(rise3, 0);
        wr(opsc_pkg::REG_CLKCTL, 4'h6);
        wr(opsc_pkg::REG_DATA, 4'h7);
        window();
        chkn(rise3, 0);
        chk(pin_out[3], 1'b0);
        wr(opsc_pkg::REG_FLOAT, 4'h8);
        settle();
        chk(pin_oe_out, 4'h7);
    endtask
    // Reset is held ten cycles; the pins must already be low and driven.
    initial begin
        repeat (9) @(posedge clk_in);
        #1 chk(pin_out, 4'h0);
        chk(pin_oe_out, 4'hF);
        @(posedge clk_in);
        rst_in <= 1'b0;
        rd(opsc_pkg::REG_DATA, 4'h0);
        rd(opsc_pkg::REG_FLOAT, 4'h0);
        rd(opsc_pkg::REG_CLKCTL, 4'h0);
        t_regs();
        t_plain();
        t_timer();
        t_osc();
        conclude();
    end
    // The tests need about 7000 cycles; the limit leaves ample margin.
    initial begin
        #300000;
        n_fail++;
        conclude();
    end
endmodule
